// ---- bench/pem_port_e_upper_pin_mux_tb.sv ----
/*
 * Self-checking bench for the upper-half port pin multiplexer.
 * Runs a full member and a reduced member without the external bus side by side.
 */
`timescale 1ns/1ps

module pem_port_e_upper_pin_mux_tb;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic              aclk    = 1'b0;
	logic              aresetn = 1'b0;
	logic              awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic              awr, wrdy, bv, arr, rv, pu;
	logic [7:0]        awa = 8'h00, ara = 8'h00, lat, p8;
	logic [31:0]       wd = 32'h0, rdat;
	logic [1:0]        bresp, rresp;
	logic              sel = 1'b1, mcu = 1'b1;
	pem_pkg::pem_alt_t alt = '0;
	pem_pkg::pem_bus_t eb  = '0;
	logic [3:0]        cap, din, pout, poe, pin = 4'h0;
	logic [33:0]       rq[$];
	logic [1:0]        bq[$];
	logic [7:0]        sq[$];
	logic [31:0]       rdat_s;
	logic [3:0]        din_s, poe_s;
	int                n_errors = 0;
	int                checks   = 0;

	pem_port_e_upper_pin_mux DUT (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
		.channel_two_pin_select(sel), .microcontroller_mode(mcu),
		.alt(alt), .ext_bus(eb), .capture_in(cap), .ext_bus_din(din),
		.pin_in(pin), .pin_out(pout), .pin_oe(poe), .port_e_pullup_enable(pu)
	);

	// Reduced member without the external bus sees the same stimulus.
	pem_port_e_upper_pin_mux #(
		.EXT_BUS_PRESENT(1'b0), .REDUCED_MEMBER(1'b1)
	) dut_small (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awv), .s_axi_awready(), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_bvalid(), .s_axi_bready(br), .s_axi_bresp(),
		.s_axi_arvalid(arv), .s_axi_arready(), .s_axi_araddr(ara),
		.s_axi_rvalid(), .s_axi_rready(rr), .s_axi_rdata(rdat_s), .s_axi_rresp(),
		.channel_two_pin_select(sel), .microcontroller_mode(mcu),
		.alt(alt), .ext_bus(eb), .capture_in(), .ext_bus_din(din_s),
		.pin_in(pin), .pin_out(), .pin_oe(poe_s), .port_e_pullup_enable()
	);

	always #12.5 aclk = ~aclk;

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp, input string nm);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic pchk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
		chk({30'h0, seen}, {30'h0, exp}, nm);
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Each bus task starts one edge late so no signal is assigned twice in a step.
	task automatic bwr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		logic pa;
		logic pw;
		@(posedge aclk);
		pa = 1'b1;
		pw = 1'b1;
		bq.push_back(er);
		awa <= a;
		wd <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		while (pa || pw) begin
			@(posedge aclk);
			if (pa && awr) begin
				pa = 1'b0;
				awv <= 1'b0;
			end
			if (pw && wrdy) begin
				pw = 1'b0;
				wv <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bv);
		br <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge aclk);
		rq.push_back({er, 24'h0, d});
		sq.push_back(d & ((a == pem_pkg::OFS_PAD_CONFIG) ? pem_pkg::MASK_PAD_SMALL :
			(a == pem_pkg::OFS_OPEN_DRAIN_2) ? pem_pkg::MASK_OD2_REDUCED : 8'hff));
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do @(posedge aclk); while (!arr);
		arv <= 1'b0;
		do @(posedge aclk); while (!rv);
		rr <= 1'b0;
	endtask

	task automatic summarize;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Response monitor
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (rv && rr) begin
			chk({rresp, rdat}, rq.pop_front(), "read");
			chk({2'b00, rdat_s}, {26'h0, sq.pop_front()}, "read_small");
		end
		if (bv && br)
			chk({32'h0, bresp}, {32'h0, bq.pop_front()}, "bresp");
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'h1805));
		wait_n(6);
		aresetn <= 1'b1;
		rd(pem_pkg::OFS_DIRECTION, 8'hff, pem_pkg::RESP_OKAY);
		rd(pem_pkg::OFS_OUTPUT_LATCH, 8'h00, pem_pkg::RESP_OKAY);
		pchk("oe_rst", poe, 4'h0);
		lat = 8'($urandom);
		p8 = 8'($urandom);
		bwr(pem_pkg::OFS_OUTPUT_LATCH, lat, pem_pkg::RESP_OKAY);
		bwr(pem_pkg::OFS_DIRECTION, 8'h0f, pem_pkg::RESP_OKAY);
		wait_n(3);
		pchk("oe_out", poe, 4'hf);
		pchk("out_latch", pout, lat[7:4]);
		pin <= p8[3:0];
		bwr(pem_pkg::OFS_DIRECTION, 8'hff, pem_pkg::RESP_OKAY);
		wait_n(5);
		pchk("oe_in", poe, 4'h0);
		rd(pem_pkg::OFS_PIN_LEVELS, {p8[3:0], 4'h0}, pem_pkg::RESP_OKAY);
		lat = ~lat;
		bwr(pem_pkg::OFS_PIN_LEVELS, lat, pem_pkg::RESP_OKAY);
		rd(pem_pkg::OFS_OUTPUT_LATCH, lat, pem_pkg::RESP_OKAY);
		// Channels 8, 7, 6 with pin 7 left unrouted.
		alt.cc_en <= 4'h7;
		alt.cc_out <= p8[7:4];
		wait_n(5);
		pchk("capture", cap, {1'b0, p8[2:0]});
		bwr(pem_pkg::OFS_DIRECTION, 8'h00, pem_pkg::RESP_OKAY);
		wait_n(3);
		pchk("out_cc", pout, {lat[7], p8[6:4]});
		pchk("oe_cc", poe, 4'hf);
		alt.cc_en <= 4'h8;
		alt.cc_out <= {~lat[7], 3'h0};
		for (int i = 0; i < 4; i++) begin
			sel <= i[0];
			mcu <= i[1];
			wait_n(3);
			pchk("pin7", {3'h0, pout[3]}, {3'h0, (i == 2) ? ~lat[7] : lat[7]});
		end
		sel <= 1'b0;
		bwr(pem_pkg::OFS_DIRECTION, 8'hff, pem_pkg::RESP_OKAY);
		wait_n(5);
		pchk("capture7", cap, {p8[3], 3'h0});
		// Enhanced PWM outputs, then shutdown tri-state on alternate pins.
		alt.cc_en <= 4'h0;
		alt.pwm_en <= 4'hf;
		alt.pwm_out <= ~p8[7:4];
		wait_n(3);
		pchk("oe_pwm_in", poe, 4'h0);
		bwr(pem_pkg::OFS_DIRECTION, 8'h00, pem_pkg::RESP_OKAY);
		wait_n(3);
		pchk("out_pwm", pout, ~p8[7:4]);
		alt.pwm_shut <= 4'hf;
		alt.pwm_tri <= 4'h5;
		wait_n(3);
		pchk("oe_shut", poe, 4'ha);
		// External bus ignores direction.
		p8 = 8'($urandom);
		bwr(pem_pkg::OFS_DIRECTION, 8'hff, pem_pkg::RESP_OKAY);
		eb.active <= 1'b1;
		eb.drive <= 4'h9;
		eb.dout <= p8[3:0];
		pin <= p8[7:4];
		wait_n(5);
		pchk("oe_bus", poe, 4'h9);
		pchk("out_bus", pout & 4'h9, p8[3:0] & 4'h9);
		pchk("bus_din", din, p8[7:4]);
		pchk("bus_din_small", din_s, 4'h0);
		pchk("oe_small", poe_s, 4'h0);
		eb.active <= 1'b0;
		bwr(8'h40, 8'h55, pem_pkg::RESP_SLVERR);
		rd(8'h40, 8'h00, pem_pkg::RESP_SLVERR);
		bwr(pem_pkg::OFS_PAD_CONFIG, 8'hff, pem_pkg::RESP_OKAY);
		rd(pem_pkg::OFS_PAD_CONFIG, pem_pkg::MASK_PAD_FULL, pem_pkg::RESP_OKAY);
		pchk("pullup", {3'h0, pu}, 4'h1);
		bwr(pem_pkg::OFS_OPEN_DRAIN_2, 8'hff, pem_pkg::RESP_OKAY);
		rd(pem_pkg::OFS_OPEN_DRAIN_2, 8'hff, pem_pkg::RESP_OKAY);
		wait_n(3);
		summarize();
	end

	// The whole sequence needs well under a thousand cycles.
	initial begin
		wait_n(20000);
		n_errors++;
		summarize();
	end

endmodule

// ---- common/pem_pkg.sv ----
/*
 * Constants, register map and carrier types for the upper-half port pin
 * multiplexer. Assumes an AXI4-Lite master with 32-bit data.
 */
package pem_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int          ADDR_W            = 8;
	localparam logic [7:0]  OFS_PIN_LEVELS    = 8'h00;
	localparam logic [7:0]  OFS_OUTPUT_LATCH  = 8'h04;
	localparam logic [7:0]  OFS_DIRECTION     = 8'h08;
	localparam logic [7:0]  OFS_PAD_CONFIG    = 8'h0c;
	localparam logic [7:0]  OFS_OPEN_DRAIN_1  = 8'h10;
	localparam logic [7:0]  OFS_OPEN_DRAIN_2  = 8'h14;

	// ------------------------------------------------------------
	// Reset values and implemented bits
	// ------------------------------------------------------------
	localparam logic [7:0]  RST_LATCH         = 8'h00;
	localparam logic [7:0]  RST_DIRECTION     = 8'hff;
	localparam logic [7:0]  RST_PAD_CONFIG    = 8'h00;
	localparam logic [7:0]  RST_OPEN_DRAIN    = 8'h00;
	localparam logic [7:0]  MASK_PAD_FULL     = 8'he6;
	localparam logic [7:0]  MASK_PAD_SMALL    = 8'hc6;
	localparam logic [7:0]  MASK_OD1          = 8'he1;
	localparam logic [7:0]  MASK_OD2_FULL     = 8'hff;
	localparam logic [7:0]  MASK_OD2_REDUCED  = 8'h3f;
	localparam logic [7:0]  MASK_UPPER_PINS   = 8'hf0;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int          UPPER_LSB         = 4;
	localparam int          PAD_PULLUP_BIT    = 6;
	localparam int          OD1_CH2_BIT       = 6;
	localparam int          OD2_CH8_BIT       = 5;
	localparam int          OD2_CH7_BIT       = 4;
	localparam int          OD2_CH6_BIT       = 3;
	localparam int          OD2_CH9_BIT       = 6;
	localparam int          OD2_CH10_BIT      = 7;
	localparam int          CH2_PIN           = 3;

	// ------------------------------------------------------------
	// Bus responses
	// ------------------------------------------------------------
	localparam logic [1:0]  RESP_OKAY         = 2'b00;
	localparam logic [1:0]  RESP_SLVERR       = 2'b10;

	// ------------------------------------------------------------
	// Carriers, index 0..3 stands for pins 4..7
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0] cc_en;
		logic [3:0] cc_out;
		logic [3:0] pwm_en;
		logic [3:0] pwm_out;
		logic [3:0] pwm_shut;
		logic [3:0] pwm_tri;
	} pem_alt_t;

	typedef struct packed {
		logic       active;
		logic [3:0] drive;
		logic [3:0] dout;
	} pem_bus_t;

endpackage

// ---- rtl/pem_port_e_upper_pin_mux.sv ----
/*
 * Pin multiplexing and direction logic for pins 4 to 7 of an 8-bit port,
 * with an AXI4-Lite register slave. Assumes peripheral and configuration
 * inputs come from logic on aclk; only the pin levels are asynchronous.
 */
`timescale 1ns/1ps

module pem_port_e_upper_pin_mux #(
	parameter bit EXT_BUS_PRESENT = 1'b1,
	parameter bit REDUCED_MEMBER  = 1'b0
) (
	// Clock and reset
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	// AXI4-Lite write
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [pem_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	output logic [1:0]                      s_axi_bresp,
	// AXI4-Lite read
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	input  wire logic [pem_pkg::ADDR_W-1:0] s_axi_araddr,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	// Configuration
	input  wire logic                       channel_two_pin_select,
	input  wire logic                       microcontroller_mode,
	// Peripherals
	input  wire pem_pkg::pem_alt_t          alt,
	input  wire pem_pkg::pem_bus_t          ext_bus,
	output logic [3:0]                      capture_in,
	output logic [3:0]                      ext_bus_din,
	// Pads
	input  wire logic [3:0]                 pin_in,
	output logic [3:0]                      pin_out,
	output logic [3:0]                      pin_oe,
	output logic                            port_e_pullup_enable
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] wd,
		input logic [3:0] strb, input logic [7:0] mask);
		merge_byte = strb[0] ? (wd[7:0] & mask) : old;
	endfunction

	// Open-drain channels only drive the pad low; a high releases it.
	function automatic logic drive_enable(input logic od, input logic level);
		drive_enable = od ? ~level : 1'b1;
	endfunction

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0]                 latch_q;
	logic [7:0]                 dir_q;
	logic [7:0]                 pad_q;
	logic [7:0]                 od1_q;
	logic [7:0]                 od2_q;
	logic [3:0]                 sync1_q;
	logic [3:0]                 sync2_q;
	logic [3:0]                 pin_out_q;
	logic [3:0]                 pin_oe_q;
	logic [3:0]                 capture_q;
	logic [3:0]                 bus_din_q;
	logic                       aw_held_q;
	logic                       w_held_q;
	logic [pem_pkg::ADDR_W-1:0] awaddr_q;
	logic [31:0]                wdata_q;
	logic [3:0]                 wstrb_q;
	logic                       bvalid_q;
	logic [1:0]                 bresp_q;
	logic                       rvalid_q;
	logic [31:0]                rdata_q;
	logic [1:0]                 rresp_q;
	logic                       awready_q;
	logic                       wready_q;
	logic                       arready_q;

	wire logic [7:0] pad_mask = EXT_BUS_PRESENT ? pem_pkg::MASK_PAD_FULL : pem_pkg::MASK_PAD_SMALL;
	wire logic [7:0] od2_mask = REDUCED_MEMBER ? pem_pkg::MASK_OD2_REDUCED : pem_pkg::MASK_OD2_FULL;

	// ------------------------------------------------------------
	// Pin muxing
	// ------------------------------------------------------------
	wire logic       route_ch2 = ~channel_two_pin_select & microcontroller_mode;
	wire logic       bus_act   = EXT_BUS_PRESENT & ext_bus.active;
	wire logic [3:0] dir_up    = dir_q[7:4];
	wire logic [3:0] latch_up  = latch_q[7:4];
	wire logic [3:0] pin_route = {route_ch2, 3'b111};
	wire logic [3:0] cc_act    = alt.cc_en & pin_route;
	wire logic [3:0] pwm_act   = alt.pwm_en & pin_route;
	wire logic [3:0] cc_od     = {od1_q[pem_pkg::OD1_CH2_BIT], od2_q[pem_pkg::OD2_CH6_BIT],
		od2_q[pem_pkg::OD2_CH7_BIT], od2_q[pem_pkg::OD2_CH8_BIT]};
	logic [3:0] out_d;
	logic [3:0] oe_d;

	for (genvar i = 0; i < 4; i++) begin : g_pin
		// Bus first, then input, then capture/compare, then PWM, then latch.
		assign out_d[i] = bus_act ? ext_bus.dout[i] :
			cc_act[i] ? alt.cc_out[i] :
			pwm_act[i] ? alt.pwm_out[i] : latch_up[i];
		assign oe_d[i] = bus_act ? ext_bus.drive[i] :
			dir_up[i] ? 1'b0 :
			cc_act[i] ? drive_enable(cc_od[i], alt.cc_out[i]) :
			pwm_act[i] ? ~(alt.pwm_shut[i] & alt.pwm_tri[i]) : 1'b1;
	end

	wire logic [3:0] capture_d = cc_act & dir_up & sync2_q & {4{~bus_act}};
	wire logic [3:0] bus_din_d = sync2_q & {4{bus_act}};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q   <= 4'h0;
			sync2_q   <= 4'h0;
			pin_out_q <= 4'h0;
			pin_oe_q  <= 4'h0;
			capture_q <= 4'h0;
			bus_din_q <= 4'h0;
		end else begin
			sync1_q   <= pin_in;
			sync2_q   <= sync1_q;
			pin_out_q <= out_d;
			pin_oe_q  <= oe_d;
			capture_q <= capture_d;
			bus_din_q <= bus_din_d;
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------
	wire logic                       aw_take = s_axi_awvalid & s_axi_awready;
	wire logic                       w_take  = s_axi_wvalid & s_axi_wready;
	wire logic                       aw_have = aw_held_q | aw_take;
	wire logic                       w_have  = w_held_q | w_take;
	wire logic                       wr_go   = aw_have & w_have & ~bvalid_q;
	wire logic [pem_pkg::ADDR_W-1:0] wa      = aw_held_q ? awaddr_q : s_axi_awaddr;
	wire logic [31:0]                wd      = w_held_q ? wdata_q : s_axi_wdata;
	wire logic [3:0]                 ws      = w_held_q ? wstrb_q : s_axi_wstrb;
	wire logic                       wr_lat  = wr_go & ((wa == pem_pkg::OFS_PIN_LEVELS) |
		(wa == pem_pkg::OFS_OUTPUT_LATCH));
	wire logic                       wr_dir  = wr_go & (wa == pem_pkg::OFS_DIRECTION);
	wire logic                       wr_pad  = wr_go & (wa == pem_pkg::OFS_PAD_CONFIG);
	wire logic                       wr_od1  = wr_go & (wa == pem_pkg::OFS_OPEN_DRAIN_1);
	wire logic                       wr_od2  = wr_go & (wa == pem_pkg::OFS_OPEN_DRAIN_2);
	wire logic                       wr_hit  = wr_lat | wr_dir | wr_pad | wr_od1 | wr_od2;
	wire logic                       aw_held_d = aw_have & ~wr_go;
	wire logic                       w_held_d  = w_have & ~wr_go;
	wire logic                       bvalid_d  = wr_go | (bvalid_q & ~s_axi_bready);

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= 32'h0;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= pem_pkg::RESP_OKAY;
		end else begin
			aw_held_q <= aw_have & ~wr_go;
			w_held_q  <= w_have & ~wr_go;
			if (aw_take) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_hit ? pem_pkg::RESP_OKAY : pem_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Writing the pin-levels register lands in the latch, as on any port.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			latch_q <= pem_pkg::RST_LATCH;
			dir_q   <= pem_pkg::RST_DIRECTION;
			pad_q   <= pem_pkg::RST_PAD_CONFIG;
			od1_q   <= pem_pkg::RST_OPEN_DRAIN;
			od2_q   <= pem_pkg::RST_OPEN_DRAIN;
		end else begin
			latch_q <= wr_lat ? merge_byte(latch_q, wd, ws, 8'hff) : latch_q;
			dir_q   <= wr_dir ? merge_byte(dir_q, wd, ws, 8'hff) : dir_q;
			pad_q   <= wr_pad ? merge_byte(pad_q, wd, ws, pad_mask) : pad_q;
			od1_q   <= wr_od1 ? merge_byte(od1_q, wd, ws, pem_pkg::MASK_OD1) : od1_q;
			od2_q   <= wr_od2 ? merge_byte(od2_q, wd, ws, od2_mask) : od2_q;
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------
	// Lower pins belong to another block, so their levels read as zero here.
	wire logic [7:0] levels_rd = {sync2_q, 4'h0} & pem_pkg::MASK_UPPER_PINS;
	wire logic       rd_take   = s_axi_arvalid & s_axi_arready;
	wire logic       rvalid_d  = rd_take | (rvalid_q & ~s_axi_rready);
	logic [7:0]      rd_byte;
	logic            rd_hit;

	always_comb begin
		rd_hit  = 1'b1;
		case (s_axi_araddr)
			pem_pkg::OFS_PIN_LEVELS:   rd_byte = levels_rd;
			pem_pkg::OFS_OUTPUT_LATCH: rd_byte = latch_q;
			pem_pkg::OFS_DIRECTION:    rd_byte = dir_q;
			pem_pkg::OFS_PAD_CONFIG:   rd_byte = pad_q;
			pem_pkg::OFS_OPEN_DRAIN_1: rd_byte = od1_q;
			pem_pkg::OFS_OPEN_DRAIN_2: rd_byte = od2_q & od2_mask;
			default: begin
				rd_byte = 8'h00;
				rd_hit  = 1'b0;
			end
		endcase
	end

	assign s_axi_arready = arready_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0;
			rresp_q  <= pem_pkg::RESP_OKAY;
		end else if (rd_take) begin
			rvalid_q <= 1'b1;
			rdata_q  <= {24'h0, rd_byte};
			rresp_q  <= rd_hit ? pem_pkg::RESP_OKAY : pem_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Ready flags are registered from next-state terms, so every port comes from a flop.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			arready_q <= 1'b1;
		end else begin
			awready_q <= ~aw_held_d & ~bvalid_d;
			wready_q  <= ~w_held_d & ~bvalid_d;
			arready_q <= ~rvalid_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign s_axi_bvalid         = bvalid_q;
	assign s_axi_bresp          = bresp_q;
	assign s_axi_rvalid         = rvalid_q;
	assign s_axi_rdata          = rdata_q;
	assign s_axi_rresp          = rresp_q;
	assign pin_out              = pin_out_q;
	assign pin_oe               = pin_oe_q;
	assign capture_in           = capture_q;
	assign ext_bus_din          = bus_din_q;
	assign port_e_pullup_enable = pad_q[pem_pkg::PAD_PULLUP_BIT];

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_plain_output(int i);
		!bus_act && !dir_up[i] && !cc_act[i] && !pwm_act[i];
	endsequence

	sequence s_pins_quiet;
		$stable(pin_in) [*2];
	endsequence

	for (genvar i = 0; i < 4; i++) begin : g_chk
		a_latch_drive: assert property (s_plain_output(i) |=> pin_oe_q[i] && pin_out_q[i] == $past(latch_up[i]))
			else $error("latch not driven on output pin");
		a_input_release: assert property (!bus_act && dir_up[i] |=> !pin_oe_q[i])
			else $error("input pin still driven");
		a_capture_idle: assert property (!dir_up[i] |=> !capture_q[i])
			else $error("capture fed while pin drives");
		a_ccp_override: assert property (!bus_act && !dir_up[i] && cc_act[i] |=> pin_out_q[i] == $past(alt.cc_out[i]))
			else $error("compare output did not override latch");
		a_pwm_shutdown: assert property (!bus_act && !dir_up[i] && !cc_act[i] && pwm_act[i] && alt.pwm_shut[i]
			&& alt.pwm_tri[i] |=> !pin_oe_q[i])
			else $error("pwm pin driven during shutdown");
		a_bus_override: assert property (bus_act |=> pin_oe_q[i] == $past(ext_bus.drive[i])
			&& pin_out_q[i] == $past(ext_bus.dout[i]))
			else $error("external bus did not own pin");
	end

	a_capture_feed: assert property (!bus_act && dir_up[0] && cc_act[0] && sync2_q[0] |=> capture_q[0])
		else $error("capture input not fed from pin");
	a_ch2_routing: assert property (!route_ch2 |=> capture_q[pem_pkg::CH2_PIN] == 1'b0)
		else $error("channel two captured on unrouted pin");
	a_ch2_override: assert property (!bus_act && !dir_up[3] && alt.cc_en[3] && route_ch2
		|=> pin_out_q[3] == $past(alt.cc_out[3]))
		else $error("channel two did not override pin seven");
	a_bus_absent: assert property (!EXT_BUS_PRESENT |-> ##1 bus_din_q == 4'h0)
		else $error("bus function present on small member");
	a_od_reserved: assert property (rd_take && s_axi_araddr == pem_pkg::OFS_OPEN_DRAIN_2 && REDUCED_MEMBER
		|=> rdata_q[pem_pkg::OD2_CH10_BIT:pem_pkg::OD2_CH9_BIT] == 2'b00)
		else $error("absent open-drain bits read nonzero");
	a_write_answer: assert property (wr_go |=> s_axi_bvalid)
		else $error("write answer missing");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped before taken");
	a_read_answer: assert property (rd_take |=> s_axi_rvalid)
		else $error("read answer missing");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer dropped before taken");
	a_unmapped_write: assert property (wr_go && !wr_hit
		|=> $stable(latch_q) && $stable(dir_q) && $stable(pad_q) && s_axi_bresp == pem_pkg::RESP_SLVERR)
		else $error("unmapped write changed state");
	a_levels_sync: assert property (s_pins_quiet |-> sync2_q == pin_in)
		else $error("pin level not synchronised in two cycles");

endmodule
